// >>> adc_touch_cfg.svh
/*
 Register offsets, field positions, reset values and timing counts for
 the converter and touch-panel supervisor. Assumes nothing else.
*/
`ifndef ADC_TOUCH_CFG_SVH
`define ADC_TOUCH_CFG_SVH

// ****************************************
// Offsets
// ****************************************
`define OFS_AD_CONFIG     8'h07
`define OFS_TOUCH_MODE    8'h08
`define OFS_RESULT_LOW    8'h09
`define OFS_RESULT_HIGH   8'h0a
`define OFS_SUPPLY_GOOD   8'h0b

// ****************************************
// Fields and reset values
// ****************************************
`define BIT_AD_ENABLE     7
`define BIT_CONV_START    6
`define BIT_END_OF_CONV   5
`define BIT_VREF_ENABLE   4
`define BIT_BELOW_THRESH  7
`define RST_TOUCH_MODE    3'h7
`define RST_GOOD_DELAY    2'h3
`define RST_INPUT_SELECT  4'h0

// ****************************************
// Timing
// ****************************************
`define CLK_HZ            50000000
`define DELAY_00_MS       20
`define DELAY_01_MS       100
`define DELAY_10_MS       200
`define DELAY_11_MS       400
`define MS_TO_CYCLES(ms)  ((ms) * (`CLK_HZ / 1000))

`endif

// >>> adc_touch_pkg.sv
/*
 Types shared by the supervisor, its checker and its bench. Assumes the
 configuration header is compiled alongside.
*/
package adc_touch_pkg;

   typedef enum logic [2:0] {
      TM_XPOS, TM_YPOS, TM_PRESSURE, TM_PLATE_X,
      TM_PLATE_Y, TM_STANDBY, TM_PLAIN, TM_OFF
   } touch_mode_t;

   typedef enum logic [1:0] {
      PIN_OPEN, PIN_REF, PIN_GND, PIN_SENSE
   } pin_drive_t;

   typedef struct packed {
      pin_drive_t x_plus;
      pin_drive_t x_minus;
      pin_drive_t y_plus;
      pin_drive_t y_minus;
   } panel_drive_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage

// >>> result_store.sv
/*
 Holds the 10-bit conversion result and returns it split over two
 register bytes from a read register. Assumes a synchronous clock and
 reset from the parent.
*/
`timescale 1ns/100ps
`include "adc_touch_cfg.svh"

module result_store #(
   parameter int WIDTH = 10
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              load,
   input  wire logic [WIDTH-1:0]  data_in,
   input  wire logic              sel_high,
   output logic       [7:0]       rdata
);

   if (WIDTH != 10) begin : g_bad_width
      $error("result_store serves only 10 bits");
   end

   typedef struct packed {
      logic [WIDTH-1:0] word;
      logic [7:0]       rdata;
   } state_t;

   state_t st_q;
   state_t st_d;

   always_comb begin
      st_d = st_q;
      if (load) begin
         st_d.word = data_in;
      end
      // Upper byte keeps bits above the result at zero.
      if (sel_high) begin
         st_d.rdata = {6'h00, st_q.word[9:8]};
      end else begin
         st_d.rdata = st_q.word[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;

endmodule // result_store

// >>> adc_touch_supervisor_regs.sv
/*
 Converter input selection, touch-panel drive, result registers and
 supply-good status with reset and supply-good output delay. Assumes a
 byte register port driven synchronously to ref_clk, and an analog
 converter that raises conv_done for one cycle with its result.
*/
`timescale 1ns/100ps
`include "adc_touch_cfg.svh"

module adc_touch_supervisor_regs #(
   parameter int RES_WIDTH  = 10,
   parameter int DELAY_00   = `MS_TO_CYCLES(`DELAY_00_MS),
   parameter int DELAY_01   = `MS_TO_CYCLES(`DELAY_01_MS),
   parameter int DELAY_10   = `MS_TO_CYCLES(`DELAY_10_MS),
   parameter int DELAY_11   = `MS_TO_CYCLES(`DELAY_11_MS)
) (
   input  wire logic                       ref_clk,
   input  wire logic                       resetn,
   input  adc_touch_pkg::reg_req_t         reg_req,
   output logic [7:0]                      reg_rdata,
   input  wire logic                       conv_done,
   input  wire logic [RES_WIDTH-1:0]       conv_result,
   input  wire logic                       below_threshold,
   input  wire logic [4:0]                 supply_in_range,
   input  wire logic                       supply_ok,
   output logic                            conv_enable,
   output logic                            conv_start,
   output logic                            vref_enable,
   output logic [3:0]                      input_select,
   output logic                            high_range,
   output logic                            touch_owns_conv,
   output logic                            touch_xy_only,
   output logic                            irq_enable,
   output adc_touch_pkg::panel_drive_t     panel_drive,
   output logic                            good_output
);

   // ****************************************
   // Parameter checks
   // ****************************************
   // The result split and the 26-bit delay counter fix these limits.
   if (RES_WIDTH != 10) begin : g_bad_width
      $error("result width must be 10");
   end
   if (DELAY_00 < 1 || DELAY_01 < 1
       || DELAY_10 < 1 || DELAY_11 < 1) begin : g_bad_short
      $error("delay counts must be positive");
   end
   if (DELAY_00 >= 2**26 || DELAY_01 >= 2**26
       || DELAY_10 >= 2**26 || DELAY_11 >= 2**26) begin : g_bad_long
      $error("delay counts exceed the counter");
   end

   // ****************************************
   // Reset release
   // ****************************************
   // Every flip-flop on rst_n leaves reset on the same edge, two after the pin.
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'h1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ****************************************
   // Helpers
   // ****************************************
   function automatic adc_touch_pkg::panel_drive_t
      drive_of(input logic [2:0] mode);
      adc_touch_pkg::panel_drive_t d;
      d = '{adc_touch_pkg::PIN_OPEN, adc_touch_pkg::PIN_OPEN,
            adc_touch_pkg::PIN_OPEN, adc_touch_pkg::PIN_OPEN};
      case (adc_touch_pkg::touch_mode_t'(mode))
         adc_touch_pkg::TM_XPOS: d = '{adc_touch_pkg::PIN_REF,
            adc_touch_pkg::PIN_GND, adc_touch_pkg::PIN_SENSE,
            adc_touch_pkg::PIN_OPEN};
         adc_touch_pkg::TM_YPOS: d = '{adc_touch_pkg::PIN_SENSE,
            adc_touch_pkg::PIN_OPEN, adc_touch_pkg::PIN_REF,
            adc_touch_pkg::PIN_GND};
         adc_touch_pkg::TM_PRESSURE: d = '{adc_touch_pkg::PIN_REF,
            adc_touch_pkg::PIN_REF, adc_touch_pkg::PIN_GND,
            adc_touch_pkg::PIN_GND};
         adc_touch_pkg::TM_PLATE_X: d = '{adc_touch_pkg::PIN_REF,
            adc_touch_pkg::PIN_GND, adc_touch_pkg::PIN_OPEN,
            adc_touch_pkg::PIN_OPEN};
         adc_touch_pkg::TM_PLATE_Y: d = '{adc_touch_pkg::PIN_OPEN,
            adc_touch_pkg::PIN_OPEN, adc_touch_pkg::PIN_REF,
            adc_touch_pkg::PIN_GND};
         // Standby drives the x pair at the reference to sense a touch.
         adc_touch_pkg::TM_STANDBY: d = '{adc_touch_pkg::PIN_REF,
            adc_touch_pkg::PIN_REF, adc_touch_pkg::PIN_GND,
            adc_touch_pkg::PIN_GND};
         adc_touch_pkg::TM_PLAIN: d = '{adc_touch_pkg::PIN_SENSE,
            adc_touch_pkg::PIN_SENSE, adc_touch_pkg::PIN_SENSE,
            adc_touch_pkg::PIN_SENSE};
         default: d = '{adc_touch_pkg::PIN_OPEN, adc_touch_pkg::PIN_OPEN,
            adc_touch_pkg::PIN_OPEN, adc_touch_pkg::PIN_OPEN};
      endcase
      return d;
   endfunction

   function automatic logic [25:0] delay_of(input logic [1:0] sel);
      logic [25:0] n;
      n = 26'(DELAY_00);
      if (sel == 2'h1) begin
         n = 26'(DELAY_01);
      end else if (sel == 2'h2) begin
         n = 26'(DELAY_10);
      end else if (sel == 2'h3) begin
         n = 26'(DELAY_11);
      end
      return n;
   endfunction

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic                        ad_enable;
      logic                        conv_start;
      logic                        end_of_conv;
      logic                        vref_enable;
      logic [3:0]                  input_sel;
      logic [2:0]                  touch_mode_sel;
      logic [1:0]                  good_output_delay;
      logic [25:0]                 delay_cnt;
      logic                        good_output;
      logic [1:0]                  rd_src;
      logic [7:0]                  rdata_other;
      logic [3:0]                  mux_sel;
      logic                        high_range;
      logic                        touch_owns;
      logic                        touch_xy;
      logic                        irq_en;
      adc_touch_pkg::panel_drive_t drive;
   } state_t;

   state_t st_q;
   state_t st_d;
   logic [7:0] result_rdata;
   logic       wr_hit;

   // ****************************************
   // Result store
   // ****************************************
   // Only the completion of a started run loads, so stray done pulses
   // from the converter cannot overwrite a result not yet read.
   result_store #(
      .WIDTH (RES_WIDTH)
   ) u_result (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .load     (conv_done && st_q.conv_start),
      .data_in  (conv_result),
      .sel_high (reg_req.addr == `OFS_RESULT_HIGH),
      .rdata    (result_rdata)
   );

   assign wr_hit = reg_req.wr;

   always_comb begin
      st_d = st_q;
      // ****************************************
      // Register writes
      // ****************************************
      if (wr_hit && reg_req.addr == `OFS_AD_CONFIG) begin
         st_d.ad_enable   = reg_req.wdata[`BIT_AD_ENABLE];
         st_d.vref_enable = reg_req.wdata[`BIT_VREF_ENABLE];
         st_d.input_sel   = reg_req.wdata[3:0];
         if (reg_req.wdata[`BIT_CONV_START]) begin
            st_d.conv_start  = 1'h1;
            st_d.end_of_conv = 1'h0;
         end
      end else if (wr_hit && reg_req.addr == `OFS_TOUCH_MODE) begin
         st_d.touch_mode_sel = reg_req.wdata[2:0];
      end else if (wr_hit && reg_req.addr == `OFS_SUPPLY_GOOD) begin
         st_d.good_output_delay = reg_req.wdata[6:5];
      end
      // Completion wins over a same-cycle start write of the old run.
      if (conv_done && st_q.conv_start) begin
         st_d.conv_start  = 1'h0;
         st_d.end_of_conv = 1'h1;
      end
      // The enable being written decides, so that one write may both
      // power the converter and start it.
      if (!st_d.ad_enable) begin
         st_d.conv_start = 1'h0;
      end

      // ****************************************
      // Input routing
      // ****************************************
      st_d.mux_sel    = st_d.input_sel;
      st_d.high_range = (st_d.input_sel >= 4'h6)
                        && (st_d.input_sel <= 4'hc);
      st_d.touch_owns = (st_d.input_sel == 4'he) || (st_d.input_sel == 4'hf);
      st_d.touch_xy   = (st_d.input_sel == 4'hf);
      // The reserved code passes on unchanged and routes no channel.
      if (st_d.input_sel == 4'hd) begin
         st_d.mux_sel = 4'hd;
      end
      st_d.drive  = drive_of(st_d.touch_mode_sel);
      st_d.irq_en = (st_d.touch_mode_sel != 3'h7);

      // ****************************************
      // Supply-good output delay
      // ****************************************
      // Any dip restarts the full delay, so a glitch costs the whole wait.
      if (!supply_ok || below_threshold) begin
         st_d.delay_cnt   = delay_of(st_d.good_output_delay);
         st_d.good_output = 1'h0;
      end else if (st_q.delay_cnt != 26'h0) begin
         st_d.delay_cnt = st_q.delay_cnt - 26'h1;
      end else begin
         st_d.good_output = 1'h1;
      end

      // ****************************************
      // Read data
      // ****************************************
      st_d.rd_src  = 2'h0;
      st_d.rdata_other = 8'h00;
      if (reg_req.addr == `OFS_AD_CONFIG) begin
         st_d.rdata_other = {st_q.ad_enable, st_q.conv_start,
                             st_q.end_of_conv, st_q.vref_enable,
                             st_q.input_sel};
      end else if (reg_req.addr == `OFS_TOUCH_MODE) begin
         st_d.rdata_other = {5'h00, st_q.touch_mode_sel};
      end else if (reg_req.addr == `OFS_RESULT_LOW
                   || reg_req.addr == `OFS_RESULT_HIGH) begin
         st_d.rd_src = 2'h1;
      end else if (reg_req.addr == `OFS_SUPPLY_GOOD) begin
         st_d.rdata_other = {below_threshold,
                             st_q.good_output_delay,
                             supply_in_range};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.end_of_conv       <= 1'h1;
         st_q.input_sel         <= `RST_INPUT_SELECT;
         st_q.touch_mode_sel    <= `RST_TOUCH_MODE;
         st_q.good_output_delay <= `RST_GOOD_DELAY;
         st_q.delay_cnt         <= 26'(DELAY_11);
         st_q.drive             <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // Read return
   // ****************************************
   // Every register answers three edges after its address appears,
   // the result bytes included, so software sees one fixed latency.
   logic [1:0] rd_src_q;
   logic [7:0] rdata_other_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_src_q      <= 2'h0;
         rdata_other_q <= 8'h00;
         reg_rdata     <= 8'h00;
      end else begin
         rd_src_q      <= st_q.rd_src;
         rdata_other_q <= st_q.rdata_other;
         reg_rdata     <= (rd_src_q == 2'h1) ? result_rdata : rdata_other_q;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Each output is a state flip-flop, so no decode glitch reaches a pin.
   assign conv_enable     = st_q.ad_enable;
   assign conv_start      = st_q.conv_start;
   assign vref_enable     = st_q.vref_enable;
   assign input_select    = st_q.mux_sel;
   assign high_range      = st_q.high_range;
   assign touch_owns_conv = st_q.touch_owns;
   assign touch_xy_only   = st_q.touch_xy;
   assign irq_enable      = st_q.irq_en;
   assign panel_drive     = st_q.drive;
   assign good_output     = st_q.good_output;

endmodule // adc_touch_supervisor_regs

// >>> adc_touch_checker_assertions.sv
/*
 Port checker for the converter supervisor, bound into every instance.
 Assumes the top module's port names and the package types.
*/
`timescale 1ns/100ps
module adc_touch_checker #(
   parameter int RES_WIDTH = 10
) (
   input wire logic                    ref_clk,
   input wire logic                    resetn,
   input adc_touch_pkg::reg_req_t      reg_req,
   input wire logic [7:0]              reg_rdata,
   input wire logic                    conv_done,
   input wire logic [RES_WIDTH-1:0]    conv_result,
   input wire logic                    below_threshold,
   input wire logic [4:0]              supply_in_range,
   input wire logic                    supply_ok,
   input wire logic                    conv_start,
   input wire logic [3:0]              input_select,
   input wire logic                    high_range,
   input wire logic                    touch_owns_conv,
   input wire logic                    touch_xy_only,
   input wire logic                    irq_enable,
   input adc_touch_pkg::panel_drive_t  panel_drive,
   input wire logic                    good_output
);
   // ****************************************
   // Properties
   // ****************************************
   // The age counter keeps read checks off the reset pipeline.
   logic [3:0]           up_q;
   logic [RES_WIDTH-1:0] res_q;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         up_q <= 4'h0;
         res_q <= '0;
      end else begin
         if (up_q != 4'h8)
            up_q <= up_q + 4'h1;
         if (conv_done && conv_start)
            res_q <= conv_result;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_hold(a);
      (up_q[3] && reg_req.addr == a && !conv_done)[*5];
   endsequence
   sequence s_stat;
      (up_q[3] && reg_req.addr == 8'h0b && $stable(below_threshold)
         && $stable(supply_in_range))[*6];
   endsequence
   AST_RES_LOW: assert property (s_hold(8'h09) |->
      reg_rdata == res_q[7:0]) else $error("result low byte wrong");
   AST_RES_HIGH: assert property (s_hold(8'h0a) |->
      reg_rdata == {6'h00, res_q[9:8]}) else $error("result high wrong");
   AST_BELOW: assert property (s_stat |->
      reg_rdata[7] == below_threshold) else $error("threshold bit wrong");
   AST_SUPPLY: assert property (s_stat |->
      reg_rdata[4:0] == supply_in_range) else $error("supply bits wrong");
   AST_RANGE: assert property (high_range ==
      (input_select >= 4'h6 && input_select <= 4'hc))
      else $error("range flag wrong");
   AST_TOUCH_ALL: assert property (input_select == 4'he |->
      touch_owns_conv && !touch_xy_only) else $error("touch all wrong");
   AST_TOUCH_XY: assert property (touch_xy_only |->
      input_select == 4'hf) else $error("xy only wrong");
   AST_OPEN: assert property (irq_enable == (panel_drive != 8'h00))
      else $error("interrupt enable and open pins disagree");
   AST_XPOS: assert property (reg_req.wr && reg_req.addr == 8'h08
      && reg_req.wdata[2:0] == 3'h0 |-> ##[1:3] panel_drive == 8'h6c)
      else $error("x position drive wrong");
   AST_DONE: assert property (conv_start && conv_done |=> !conv_start)
      else $error("start not cleared");
   AST_START_HOLD: assert property (conv_start && !conv_done
      && !(reg_req.wr && reg_req.addr == 8'h07) |=> conv_start)
      else $error("start dropped early");
   AST_GOOD: assert property ($rose(good_output) |->
      supply_ok && $past(supply_ok, 8)) else $error("good output early");
endmodule // adc_touch_checker
bind adc_touch_supervisor_regs adc_touch_checker #(.RES_WIDTH(RES_WIDTH)) chk_u (
   .ref_clk, .resetn, .reg_req, .reg_rdata, .conv_done, .conv_result,
   .below_threshold, .supply_in_range, .supply_ok, .conv_start,
   .input_select, .high_range, .touch_owns_conv, .touch_xy_only,
   .irq_enable, .panel_drive, .good_output);

// >>> adc_conv_model.sv
/*
 Behavioural analog converter facing the supervisor. Assumes the bench
 sets the level seen on the selected channel and the conversion time.
*/
`timescale 1ns/100ps
module adc_conv_model (
   input wire logic        ref_clk,
   input wire logic        conv_enable,
   input wire logic        conv_start,
   input wire logic [3:0]  wait_cycles,
   input wire logic [9:0]  level,
   output logic            conv_done,
   output logic [9:0]      conv_result
);
   // ****************************************
   // Conversion
   // ****************************************
   // Result lines toggle outside the done pulse so stale data shows.
   int         cnt = 0;
   logic       busy = 1'b0;
   logic [9:0] junk = 10'h155;
   always @(posedge ref_clk) begin
      conv_done <= 1'b0;
      junk <= ~junk;
      conv_result <= junk;
      if (busy && cnt == 0) begin
         conv_done <= 1'b1;
         conv_result <= level;
         busy <= 1'b0;
      end else if (busy) begin
         cnt <= cnt - 1;
      end else if (conv_start && conv_enable && !conv_done) begin
         busy <= 1'b1;
         cnt <= wait_cycles;
      end
   end
endmodule // adc_conv_model

// >>> adc_touch_supervisor_regs_tb.sv
/*
 Self-checking bench for the converter supervisor. Assumes the design
 files, the checker and the converter model are compiled first.
*/
`timescale 1ns/100ps
module adc_touch_supervisor_regs_tb;
   // ****************************************
   // Bench
   // ****************************************
   // Short delays keep the run brief; expectations follow them.
   localparam int DLY [4] = '{10, 20, 30, 40};
   logic [7:0] pd_exp [8] = '{8'h6c, 8'hc6, 8'h5a, 8'h60, 8'h06, 8'h5a,
                              8'hff, 8'h00};
   logic ref_clk, resetn, conv_done, below_threshold, supply_ok;
   logic conv_enable, conv_start, vref_enable, high_range, good_output;
   logic touch_owns_conv, touch_xy_only, irq_enable;
   logic [7:0] reg_rdata, v;
   logic [9:0] conv_result, level;
   logic [4:0] supply_in_range;
   logic [3:0] input_select, wait_cycles;
   adc_touch_pkg::reg_req_t     reg_req;
   adc_touch_pkg::panel_drive_t panel_drive;
   int err_count, checks, i, n;

   adc_touch_supervisor_regs #(.DELAY_00(DLY[0]), .DELAY_01(DLY[1]),
      .DELAY_10(DLY[2]), .DELAY_11(DLY[3])) dut_u (
      .ref_clk, .resetn, .reg_req, .reg_rdata, .conv_done, .conv_result,
      .below_threshold, .supply_in_range, .supply_ok, .conv_enable,
      .conv_start, .vref_enable, .input_select, .high_range,
      .touch_owns_conv, .touch_xy_only, .irq_enable, .panel_drive,
      .good_output);
   adc_conv_model model_u (.ref_clk, .conv_enable, .conv_start,
      .wait_cycles, .level, .conv_done, .conv_result);

   always #10 ref_clk = ~ref_clk;

   task chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #2 reg_req = '{1'b1, a, d};
      @(posedge ref_clk);
      #2 reg_req.wr = 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge ref_clk);
      #2 reg_req.addr = a;
      repeat (3) @(posedge ref_clk);
      #1 r = reg_rdata;
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
      rd(a, v);
      chk(nm, e, v);
   endtask
   task test_done;
      $display("err_count %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      test_done;
   end

   initial begin
      ref_clk = 0; resetn = 0; reg_req = '0; below_threshold = 1;
      supply_in_range = 5'h15; supply_ok = 0; wait_cycles = 0; level = 0;
      err_count = 0; checks = 0;
      repeat (3) @(posedge ref_clk);
      #2 resetn = 1;
      repeat (3) @(posedge ref_clk);
      rdc("touch mode reset", 8'h08, 8'h07);
      rdc("config reset", 8'h07, 8'h20);
      rdc("status", 8'h0b, 8'hf5);
      rdc("status", 8'h0b, 8'hf5);
      rdc("unmapped", 8'h3c, 8'h00);
      for (i = 0; i < 16; i++) begin
         wr(8'h07, i[7:0]);
         repeat (2) @(posedge ref_clk);
         #1;
         chk("input select", i[9:0], input_select);
         chk("high range", i >= 6 && i <= 12, high_range);
         chk("touch all", i >= 14, touch_owns_conv);
         chk("xy only", i == 15, touch_xy_only);
      end
      wr(8'h07, 8'h90);
      chk("conv enable", 1'b1, conv_enable);
      chk("vref enable", 1'b1, vref_enable);
      for (i = 0; i < 8; i++) begin
         wr(8'h08, 8'hf8 | i[7:0]);
         rdc("touch mode", 8'h08, i[7:0]);
         chk("panel drive", pd_exp[i], panel_drive);
         chk("irq enable", i != 7, irq_enable);
      end
      wr(8'h08, 8'h00);
      for (i = 0; i < 2; i++) begin
         level = (i == 0) ? 10'h2a5 : 10'h15a;
         wait_cycles = (i == 0) ? 4'h0 : 4'hc;
         wr(8'h07, 8'hce);
         chk("start set", 1'b1, conv_start);
         if (i == 1) rdc("busy", 8'h07, 8'hce);
         v = 8'h00;
         for (n = 0; n < 40 && !v[5]; n++) rd(8'h07, v);
         chk("done", 8'hae, v);
         rdc("result low", 8'h09, level[7:0]);
         wr(8'h09, 8'hff);
         rdc("result low", 8'h09, level[7:0]);
         rdc("result high", 8'h0a, {6'h00, level[9:8]});
         wr(8'h0a, 8'hff);
         rdc("result high", 8'h0a, {6'h00, level[9:8]});
      end
      for (i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         #2 supply_ok = 0;
         below_threshold = 0;
         supply_in_range = 5'h0a;
         wr(8'h0b, {1'b0, i[1:0], 5'h1f});
         rdc("delay field", 8'h0b, {1'b0, i[1:0], 5'h0a});
         @(posedge ref_clk);
         #2 supply_ok = 1;
         n = 0;
         while (good_output !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         checks++;
         if (n < DLY[i] || n > DLY[i] + 4) begin
            err_count++;
            $display("MISMATCH good delay expected %0d seen %0d", DLY[i], n);
         end
      end
      test_done;
   end
endmodule // adc_touch_supervisor_regs_tb
